// File: fegro_top.sv
// Purpose: erase block guard, RAM overlay and error lockout for on-chip flash
// Assumes: Avalon-MM slave with waitrequest, 32-bit data, byte addresses
// Notes: answers every access on the second cycle; unmapped reads give zero
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "fegro_defines.svh"

module fegro_top
	import fegro_pkg::*;
#(
	parameter int ADDR_W = 24
)
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [3:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	input  wire logic              hard_write_enable_pin,
	input  wire logic              mode_pin_2,
	input  wire logic              mode_pin_1,
	input  wire logic              mode_pin_0,
	input  wire logic              hardStandby,
	input  wire logic              softStandby,
	input  wire logic              flashRead,
	input  wire logic [ADDR_W-1:0] flashAddr,
	input  wire logic              exceptionStart,
	input  wire logic              exceptionExempt,
	input  wire logic              sleepExec,
	output logic                   programPermit,
	output logic                   erasePermit,
	output logic [7:0]             blockEraseEnable,
	output logic                   addrEraseGrant,
	output logic                   overlayHit,
	output logic [ADDR_W-1:0]      overlayRamAddr,
	output logic                   bootMode,
	output logic                   userProgramMode,
	output logic                   flash_error_flag
);
	import fegro_pkg::*;

	// ==========================================================
	// declarations
	logic [`FEGRO_SYNC_STAGES-1:0] hweSync_r;
	logic [`FEGRO_SYNC_STAGES-1:0] md2Sync_r;
	logic [`FEGRO_SYNC_STAGES-1:0] md1Sync_r;
	logic [`FEGRO_SYNC_STAGES-1:0] md0Sync_r;
	logic                          hwe;
	fegro_mode_type                opMode;
	fegro_bus_type                 busState_r;
	fegro_bus_type                 busState_nxt;
	logic [31:0]                   readdata_nxt;
	logic                          wrTake;
	logic                          lowLane;
	logic [7:0]                    wrByte;
	logic                          soft_write_enable_r;
	logic                          programActive_r;
	logic                          eraseActive_r;
	logic [7:0]                    block_pick_bits_r;
	logic                          overlay_enable_r;
	logic                          window_select_hi_r;
	logic                          window_select_lo_r;
	logic                          flashBusy;
	logic                          entryAllowed;
	logic                          eraseSelWritable;
	logic                          overlayWritable;
	logic                          readHitsOverlay;
	logic [7:0]                    modeCtrlView;
	logic [7:0]                    eraseSelView;
	logic [7:0]                    overlayView;
	logic [7:0]                    errStatusView;

	// ==========================================================
	// functions
	// which erase block holds an address, one-hot; zero outside flash
	function automatic logic [7:0] blockOf(input logic [ADDR_W-1:0] a);
		logic [23:0] w;
		logic [7:0]  hot;
		w   = 24'(a);
		hot = 8'h00;
		if (w > `FEGRO_FLASH_END)
		begin
			hot = 8'h00;
		end
		else if (w >= `FEGRO_BLK7_BASE)
		begin
			hot = 8'h80;
		end
		else if (w >= `FEGRO_BLK6_BASE)
		begin
			hot = 8'h40;
		end
		else if (w >= `FEGRO_BLK5_BASE)
		begin
			hot = 8'h20;
		end
		else if (w >= `FEGRO_BLK4_BASE)
		begin
			hot = 8'h10;
		end
		else
		begin
			hot = 8'h01 << w[11:10];
		end
		return hot;
	endfunction

	// does an address fall in the small block the overlay currently covers
	function automatic logic inWindow(input logic [ADDR_W-1:0] a, input logic en,
		input logic [1:0] sel);
		logic [23:0] w;
		w = 24'(a);
		return en && (w[23:12] == 12'h000) && (w[11:10] == sel);
	endfunction

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			hweSync_r <= '0;
			md2Sync_r <= '0;
			md1Sync_r <= '0;
			md0Sync_r <= '0;
		end
		else
		begin
			hweSync_r <= {hweSync_r[0], hard_write_enable_pin};
			md2Sync_r <= {md2Sync_r[0], mode_pin_2};
			md1Sync_r <= {md1Sync_r[0], mode_pin_1};
			md0Sync_r <= {md0Sync_r[0], mode_pin_0};
		end
	end

	assign hwe = hweSync_r[1];

	fegro_mode_decode u_mode
	(
		.clock           (clock),
		.reset           (reset),
		.modePin2        (md2Sync_r[1]),
		.modePin1        (md1Sync_r[1]),
		.modePin0        (md0Sync_r[1]),
		.hardWriteEnable (hwe),
		.opMode          (opMode),
		.bootMode        (bootMode),
		.userProgramMode (userProgramMode)
	);

	// ==========================================================
	// mode gating
	assign eraseSelWritable = (opMode == MODE_FIVE) || (opMode == MODE_SEVEN);
	// mode six accepts the write though emulation is unsupported there
	assign overlayWritable  = eraseSelWritable || (opMode == MODE_SIX);
	assign flashBusy        = programActive_r || eraseActive_r;
	// overlay and error protection both lock out entry
	assign entryAllowed     = hwe && soft_write_enable_r && !flash_error_flag
		&& !overlay_enable_r;

	// ==========================================================
	// register bus: one wait cycle, then answer
	assign wrTake      = write && (busState_r == BUS_ANSWER);
	assign lowLane     = byteenable[0];
	assign wrByte      = writedata[7:0];
	assign waitrequest = (read || write) && (busState_r == BUS_IDLE);

	always_comb
	begin
		busState_nxt = BUS_IDLE;
		case (busState_r)
			BUS_IDLE:   busState_nxt = (read || write) ? BUS_ANSWER : BUS_IDLE;
			BUS_ANSWER: busState_nxt = BUS_IDLE;
			default:    busState_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			busState_r <= BUS_IDLE;
		end
		else
		begin
			busState_r <= busState_nxt;
		end
	end

	// ==========================================================
	// read views
	assign modeCtrlView  = {hwe, soft_write_enable_r, 4'h0, eraseActive_r,
		programActive_r};
	assign eraseSelView  = eraseSelWritable ? block_pick_bits_r : 8'h00;
	assign overlayView   = `FEGRO_OC_FIXED_ONES
		| ({8{overlayWritable}} & {4'h0, overlay_enable_r, window_select_hi_r,
		window_select_lo_r, 1'b0});
	assign errStatusView = `FEGRO_ES_FIXED_ONES | {flash_error_flag, 7'h00};

	always_comb
	begin
		readdata_nxt = 32'h0000_0000;
		case (address)
			`FEGRO_OFS_MODE_CTRL:  readdata_nxt = {24'h000000, modeCtrlView};
			`FEGRO_OFS_ERASE_SEL:  readdata_nxt = {24'h000000, eraseSelView};
			`FEGRO_OFS_OVL_CTRL:   readdata_nxt = {24'h000000, overlayView};
			`FEGRO_OFS_ERR_STATUS: readdata_nxt = {24'h000000, errStatusView};
			default:               readdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			readdata <= 32'h0000_0000;
		end
		else if (read && (busState_r == BUS_IDLE))
		begin
			readdata <= readdata_nxt;
		end
	end

	// ==========================================================
	// flash_mode_control: soft enable and program/erase entry
	always_ff @(posedge clock)
	begin
		if (reset || hardStandby || softStandby || !hwe)
		begin
			soft_write_enable_r <= 1'b0;
		end
		else if (wrTake && lowLane && (address == `FEGRO_OFS_MODE_CTRL))
		begin
			soft_write_enable_r <= wrByte[`FEGRO_MC_SWE_BIT];
		end
	end

	// only one of program and erase may run; a trip of the flag ends both
	always_ff @(posedge clock)
	begin
		if (reset || hardStandby || softStandby || flash_error_flag || !hwe
			|| !soft_write_enable_r)
		begin
			programActive_r <= 1'b0;
			eraseActive_r   <= 1'b0;
		end
		else if (wrTake && lowLane && (address == `FEGRO_OFS_MODE_CTRL))
		begin
			programActive_r <= wrByte[`FEGRO_MC_PROG_BIT] && entryAllowed
				&& !wrByte[`FEGRO_MC_ERASE_BIT];
			eraseActive_r   <= wrByte[`FEGRO_MC_ERASE_BIT] && entryAllowed
				&& !wrByte[`FEGRO_MC_PROG_BIT];
		end
	end

	// ==========================================================
	// erase_block_select
	always_ff @(posedge clock)
	begin
		if (reset || hardStandby || softStandby || !hwe || !soft_write_enable_r)
		begin
			block_pick_bits_r <= `FEGRO_ERASE_SEL_RESET;
		end
		else if (!eraseSelWritable)
		begin
			block_pick_bits_r <= `FEGRO_ERASE_SEL_RESET;
		end
		else if (wrTake && lowLane && (address == `FEGRO_OFS_ERASE_SEL))
		begin
			block_pick_bits_r <= wrByte;
		end
	end

	// ==========================================================
	// ram_overlay_control: survives software standby
	always_ff @(posedge clock)
	begin
		if (reset || hardStandby || !overlayWritable)
		begin
			{overlay_enable_r, window_select_hi_r, window_select_lo_r}
				<= `FEGRO_OVL_BITS_RESET;
		end
		else if (wrTake && lowLane && (address == `FEGRO_OFS_OVL_CTRL))
		begin
			overlay_enable_r   <= wrByte[`FEGRO_OC_ENABLE_BIT];
			window_select_hi_r <= wrByte[`FEGRO_OC_WIN_HI_BIT];
			window_select_lo_r <= wrByte[`FEGRO_OC_WIN_LO_BIT];
		end
	end

	// ==========================================================
	// overlay remap toward the RAM window
	assign readHitsOverlay = inWindow(flashAddr, overlay_enable_r,
		{window_select_hi_r, window_select_lo_r});

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			overlayHit     <= 1'b0;
			overlayRamAddr <= '0;
		end
		else
		begin
			overlayHit     <= flashRead && readHitsOverlay;
			overlayRamAddr <= ADDR_W'(`FEGRO_OVL_RAM_BASE)
				| ADDR_W'(flashAddr[9:0]);
		end
	end

	// ==========================================================
	// error protection
	fegro_error_guard u_err
	(
		.clock           (clock),
		.reset           (reset),
		.hardStandby     (hardStandby),
		.flashBusy       (flashBusy),
		.flashRead       (flashRead),
		.readHitsOverlay (readHitsOverlay),
		.exceptionStart  (exceptionStart),
		.exceptionExempt (exceptionExempt),
		.sleepExec       (sleepExec),
		.errorFlag       (flash_error_flag)
	);

	// ==========================================================
	// permits toward the flash array
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			programPermit    <= 1'b0;
			erasePermit      <= 1'b0;
			blockEraseEnable <= 8'h00;
			addrEraseGrant   <= 1'b0;
		end
		else
		begin
			programPermit    <= programActive_r && entryAllowed;
			erasePermit      <= eraseActive_r && entryAllowed;
			blockEraseEnable <= block_pick_bits_r
				& {8{eraseActive_r && entryAllowed}};
			addrEraseGrant   <= eraseActive_r && entryAllowed
				&& ((blockOf(flashAddr) & block_pick_bits_r) != 8'h00);
		end
	end
endmodule

// File: fegro_defines.svh
// Purpose: offsets, field positions, reset values and counts of the flash guard block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, 8-bit registers in the low byte
// Notes: header only, no logic
`ifndef FEGRO_DEFINES_SVH
`define FEGRO_DEFINES_SVH

// ==========================================================
// register byte offsets
`define FEGRO_OFS_MODE_CTRL     4'h0
`define FEGRO_OFS_ERASE_SEL     4'h4
`define FEGRO_OFS_OVL_CTRL      4'h8
`define FEGRO_OFS_ERR_STATUS    4'hc

// ==========================================================
// flash_mode_control fields
`define FEGRO_MC_HWE_BIT        7
`define FEGRO_MC_SWE_BIT        6
`define FEGRO_MC_ERASE_BIT      1
`define FEGRO_MC_PROG_BIT       0

// ==========================================================
// ram_overlay_control fields and fixed bits
`define FEGRO_OC_ENABLE_BIT     3
`define FEGRO_OC_WIN_HI_BIT     2
`define FEGRO_OC_WIN_LO_BIT     1
`define FEGRO_OC_FIXED_ONES     8'hf1

// ==========================================================
// flash_error_status fields and fixed bits
`define FEGRO_ES_FLAG_BIT       7
`define FEGRO_ES_FIXED_ONES     8'h7f

// ==========================================================
// reset values
`define FEGRO_ERASE_SEL_RESET   8'h00
`define FEGRO_OVL_BITS_RESET    3'h0

// ==========================================================
// memory map of the flash and the overlay window
`define FEGRO_BLK4_BASE         24'h001000
`define FEGRO_BLK5_BASE         24'h008000
`define FEGRO_BLK6_BASE         24'h010000
`define FEGRO_BLK7_BASE         24'h018000
`define FEGRO_FLASH_END         24'h01ffff
`define FEGRO_SMALL_BLK_SIZE    24'h000400
`define FEGRO_OVL_RAM_BASE      24'hfff800

// ==========================================================
// pin synchroniser depth
`define FEGRO_SYNC_STAGES       2

`endif

// File: fegro_pkg.sv
// Purpose: shared types of the flash guard block
// Assumes: constants live in fegro_defines.svh
// Notes: types only
package fegro_pkg;

	// ==========================================================
	// register bus answer sequencing
	typedef enum logic [0:0]
	{
		BUS_IDLE,
		BUS_ANSWER
	} fegro_bus_type;

	// ==========================================================
	// decoded operating mode
	typedef enum logic [2:0]
	{
		MODE_OTHER,
		MODE_FIVE,
		MODE_SIX,
		MODE_SEVEN
	} fegro_mode_type;

endpackage

// File: fegro_mode_decode.sv
// Purpose: decode synchronised mode pins into operating and programming modes
// Assumes: pins already passed two flip-flops
// Notes: outputs registered
`timescale 1ns/1ps
module fegro_mode_decode
	import fegro_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            reset,
	input  wire logic            modePin2,
	input  wire logic            modePin1,
	input  wire logic            modePin0,
	input  wire logic            hardWriteEnable,
	output fegro_pkg::fegro_mode_type opMode,
	output logic                 bootMode,
	output logic                 userProgramMode
);
	logic [2:0]     pins;
	logic           bootPattern;
	fegro_mode_type mode_nxt;

	assign pins = {modePin2, modePin1, modePin0};
	// boot patterns carry mode pin 2 inverted
	assign bootPattern = (pins == 3'h1) || (pins == 3'h3);

	always_comb
	begin
		case (bootPattern ? {~modePin2, modePin1, modePin0} : pins)
			3'h5:    mode_nxt = MODE_FIVE;
			3'h6:    mode_nxt = MODE_SIX;
			3'h7:    mode_nxt = MODE_SEVEN;
			default: mode_nxt = MODE_OTHER;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			opMode <= MODE_OTHER;
		end
		else
		begin
			opMode <= mode_nxt;
		end
	end

	// mode six never reaches the programming modes since its patterns differ
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			bootMode        <= 1'b0;
			userProgramMode <= 1'b0;
		end
		else
		begin
			bootMode        <= hardWriteEnable && bootPattern;
			userProgramMode <= hardWriteEnable && !bootPattern && pins[0]
				&& (pins[1] || !pins[1]) && pins[2];
		end
	end
endmodule

// File: fegro_error_guard.sv
// Purpose: sticky flash error flag and error protection
// Assumes: event inputs come from logic on the same clock
// Notes: reset stands for watchdog and reset-pin resets
`timescale 1ns/1ps
module fegro_error_guard
(
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic hardStandby,
	input  wire logic flashBusy,
	input  wire logic flashRead,
	input  wire logic readHitsOverlay,
	input  wire logic exceptionStart,
	input  wire logic exceptionExempt,
	input  wire logic sleepExec,
	output logic      errorFlag
);
	logic setEvent;

	// ==========================================================
	// error causes
	assign setEvent = (flashBusy && flashRead && !readHitsOverlay)
		|| (flashBusy && exceptionStart && !exceptionExempt)
		|| (flashBusy && sleepExec);

	// set wins over standby clear so no event is lost; software has no path
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			errorFlag <= 1'b0;
		end
		else if (setEvent)
		begin
			errorFlag <= 1'b1;
		end
		else if (hardStandby)
		begin
			errorFlag <= 1'b0;
		end
	end
endmodule

// File: fegro_top_assertions.sv
// Purpose: concurrent checks on the flash guard top-level ports
// Assumes: single clock domain, synchronous active-high reset
// Notes: attached to fegro_top by the bind after the module
`timescale 1ns/1ps
module fegro_top_assertions
#(
	parameter int ADDR_W = 24
)
(
	input wire logic              clock,
	input wire logic              reset,
	input wire logic              hardStandby,
	input wire logic              flashRead,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic              exceptionStart,
	input wire logic              exceptionExempt,
	input wire logic              sleepExec,
	input wire logic              hard_write_enable_pin,
	input wire logic              mode_pin_2,
	input wire logic              mode_pin_1,
	input wire logic              mode_pin_0,
	input wire logic              programPermit,
	input wire logic              erasePermit,
	input wire logic [7:0]        blockEraseEnable,
	input wire logic              overlayHit,
	input wire logic [ADDR_W-1:0] overlayRamAddr,
	input wire logic              bootMode,
	input wire logic              userProgramMode,
	input wire logic              flash_error_flag
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (reset);

	// ==========================================================
	// error flag
	err_sticky_a: assert property (flash_error_flag && !hardStandby |=> flash_error_flag)
		else $error("error flag dropped without cause");
	err_on_read_a: assert property (flashRead && (erasePermit || programPermit)
		|=> flash_error_flag)
		else $error("flash read during erase left flag low");
	err_on_exc_a: assert property (exceptionStart && !exceptionExempt
		&& (erasePermit || programPermit) |=> flash_error_flag)
		else $error("exception during erase left flag low");
	err_on_sleep_a: assert property (sleepExec && (erasePermit || programPermit)
		|=> flash_error_flag)
		else $error("sleep during erase left flag low");
	// flag must never rise on its own
	err_cause_a: assert property ($rose(flash_error_flag)
		|-> $past(flashRead) || $past(exceptionStart) || $past(sleepExec))
		else $error("error flag rose without an event");
	err_lock_a: assert property (flash_error_flag && $past(flash_error_flag)
		|-> !programPermit && !erasePermit)
		else $error("permit while error protected");
	err_clear_a: assert property (hardStandby && !flashRead && !exceptionStart
		&& !sleepExec |=> !flash_error_flag)
		else $error("hardware standby kept error flag");

	// ==========================================================
	// erase gating, modes and overlay remap
	erase_gate_a: assert property (blockEraseEnable != 8'h00 |-> erasePermit)
		else $error("block enable without erase permit");
	// pin path is two sync stages plus one output register; seven cycles cover it with margin
	pin_low_a: assert property (!hard_write_enable_pin [*7]
		|-> blockEraseEnable == 8'h00 && !erasePermit && !programPermit
		&& !bootMode && !userProgramMode)
		else $error("activity with write enable pin low");
	mode_six_a: assert property ((mode_pin_2 && mode_pin_1 && !mode_pin_0) [*7]
		|-> !bootMode && !userProgramMode)
		else $error("programming mode entered in mode six");
	ovl_addr_a: assert property (overlayHit |-> $past(flashRead)
		&& $past(flashAddr) < 24'h001000
		&& overlayRamAddr == (24'hfff800 | ($past(flashAddr) & 24'h0003ff)))
		else $error("overlay hit or address wrong");
endmodule

bind fegro_top fegro_top_assertions #(.ADDR_W(ADDR_W)) i_fegro_top_assertions
(
	.clock                (clock),
	.reset                (reset),
	.hardStandby          (hardStandby),
	.flashRead            (flashRead),
	.flashAddr            (flashAddr),
	.exceptionStart       (exceptionStart),
	.exceptionExempt      (exceptionExempt),
	.sleepExec            (sleepExec),
	.hard_write_enable_pin(hard_write_enable_pin),
	.mode_pin_2           (mode_pin_2),
	.mode_pin_1           (mode_pin_1),
	.mode_pin_0           (mode_pin_0),
	.programPermit        (programPermit),
	.erasePermit          (erasePermit),
	.blockEraseEnable     (blockEraseEnable),
	.overlayHit           (overlayHit),
	.overlayRamAddr       (overlayRamAddr),
	.bootMode             (bootMode),
	.userProgramMode      (userProgramMode),
	.flash_error_flag     (flash_error_flag)
);

// File: fegro_top_bench.sv
// Purpose: self-checking bench of the flash guard top level
// Assumes: master waits for waitrequest low, pins need a few cycles to sync
// Notes: byteenable is tied high; partial writes are not exercised
`timescale 1ns/1ps
module fegro_top_bench;
	logic        clock;
	logic        reset;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        hard_write_enable_pin;
	logic [2:0]  modePins;
	logic        hardStandby;
	logic        softStandby;
	logic        flashRead;
	logic [23:0] flashAddr;
	logic        exceptionStart;
	logic        exceptionExempt;
	logic        sleepExec;
	logic        programPermit;
	logic        erasePermit;
	logic [7:0]  blockEraseEnable;
	logic        addrEraseGrant;
	logic        overlayHit;
	logic [23:0] overlayRamAddr;
	logic        bootMode;
	logic        userProgramMode;
	logic        flash_error_flag;
	logic [7:0]  q;
	int          errorCnt;
	int          totalChecks;

	fegro_top i_fegro_top
	(
		.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .hard_write_enable_pin(hard_write_enable_pin),
		.mode_pin_2(modePins[2]), .mode_pin_1(modePins[1]), .mode_pin_0(modePins[0]),
		.hardStandby(hardStandby), .softStandby(softStandby), .flashRead(flashRead),
		.flashAddr(flashAddr), .exceptionStart(exceptionStart),
		.exceptionExempt(exceptionExempt), .sleepExec(sleepExec),
		.programPermit(programPermit), .erasePermit(erasePermit),
		.blockEraseEnable(blockEraseEnable), .addrEraseGrant(addrEraseGrant),
		.overlayHit(overlayHit), .overlayRamAddr(overlayRamAddr), .bootMode(bootMode),
		.userProgramMode(userProgramMode), .flash_error_flag(flash_error_flag)
	);

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	// every driver starts one edge later, so no signal is driven twice at an edge
	task automatic busCycle(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= {24'h0, d};
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		busCycle(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		busCycle(1'b0, a, 8'h00);
		check({24'h0, q}, {24'h0, exp});
	endtask

	task automatic setMode(input logic pin, input logic [2:0] m);
		@(posedge clock);
		hard_write_enable_pin <= pin;
		modePins <= m;
		tick(6);
	endtask

	task automatic standby(input logic hard);
		@(posedge clock);
		if (hard) hardStandby <= 1'b1; else softStandby <= 1'b1;
		@(posedge clock);
		{hardStandby, softStandby} <= 2'b00;
	endtask

	task automatic probe(input logic [23:0] a);
		@(posedge clock);
		flashRead <= 1'b1;
		flashAddr <= a;
		@(posedge clock);
		flashRead <= 1'b0;
		@(negedge clock);
	endtask

	task automatic grant(input logic [23:0] a, input logic exp);
		@(posedge clock);
		flashAddr <= a;
		@(posedge clock);
		@(negedge clock);
		check(32'(addrEraseGrant), 32'(exp));
	endtask

	// ==========================================================
	// scenarios
	task automatic testReset();
		rd(4'h4, 8'h00);
		rd(4'h8, 8'hf1);
		rd(4'hc, 8'h7f);
		rd(4'h2, 8'h00);
		wr(4'hc, 8'h00);
		rd(4'hc, 8'h7f);
		wr(4'h8, 8'h06);
		rd(4'h8, 8'hf7);
		wr(4'h8, 8'h00);
		$display("reset test done");
	endtask

	task automatic testEraseSel();
		setMode(1'b1, 3'b101);
		rd(4'h0, 8'h80);
		wr(4'h4, 8'h01);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'h40);
		wr(4'h4, 8'h04);
		rd(4'h4, 8'h04);
		wr(4'h0, 8'h00);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'h40);
		wr(4'h4, 8'h08);
		standby(1'b0);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'h40);
		wr(4'h4, 8'h08);
		setMode(1'b0, 3'b101);
		rd(4'h4, 8'h00);
		rd(4'h0, 8'h00);
		wr(4'h0, 8'h40);
		rd(4'h0, 8'h00);
		$display("erase select test done");
	endtask

	task automatic testBlocks();
		logic [23:0] base [8];
		logic [23:0] last;
		base = '{24'h0, 24'h400, 24'h800, 24'hc00, 24'h1000, 24'h8000, 24'h10000, 24'h18000};
		setMode(1'b1, 3'b101);
		wr(4'h0, 8'h40);
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h4, 8'h01 << i);
			wr(4'h0, 8'h42);
			repeat (2) @(negedge clock);
			check(32'(blockEraseEnable), 32'h1 << i);
			last = (i < 7) ? base[i + 1] - 24'h1 : 24'h01ffff;
			grant(base[i], 1'b1);
			grant(last, 1'b1);
			grant(last + 24'h1, 1'b0);
			if (i > 0) grant(base[i] - 24'h1, 1'b0);
			wr(4'h0, 8'h40);
		end
		wr(4'h0, 8'h41);
		repeat (2) @(negedge clock);
		check(32'(programPermit), 32'h1);
		wr(4'h0, 8'h40);
		wr(4'h4, 8'h00);
		$display("block test done");
	endtask

	// kinds: read, exception, sleep, exempt exception
	task automatic testError();
		for (int k = 0; k < 4; k++)
		begin
			setMode(1'b1, 3'b111);
			wr(4'h0, 8'h40);
			wr(4'h4, 8'h01);
			wr(4'h0, 8'h42);
			@(posedge clock);
			flashRead <= (k == 0);
			flashAddr <= 24'h002000;
			exceptionStart <= (k == 1 || k == 3);
			exceptionExempt <= (k == 3);
			sleepExec <= (k == 2);
			@(posedge clock);
			{flashRead, exceptionStart, exceptionExempt, sleepExec} <= 4'h0;
			@(negedge clock);
			check(32'(flash_error_flag), 32'(k != 3));
			@(negedge clock);
			check(32'(erasePermit), 32'(k == 3));
			wr(4'h0, 8'h42);
			rd(4'h0, (k == 3) ? 8'hc2 : 8'hc0);
			wr(4'h0, 8'h40);
			wr(4'hc, 8'h00);
			rd(4'hc, (k == 3) ? 8'h7f : 8'hff);
			@(posedge clock);
			if (k == 0) reset <= 1'b1; else hardStandby <= 1'b1;
			tick(3);
			{reset, hardStandby} <= 2'b00;
			@(negedge clock);
			check(32'(flash_error_flag), 32'h0);
		end
		$display("error test done");
	endtask

	task automatic testOverlay();
		setMode(1'b1, 3'b101);
		for (int s = 0; s < 4; s++)
		begin
			wr(4'h8, 8'h08 | 8'(s << 1));
			rd(4'h8, 8'hf9 | 8'(s << 1));
			for (int j = 0; j < 2; j++)
			begin
				probe(24'(((s ^ j) * 1024) + 291));
				check(32'(overlayHit), 32'(j == 0));
				if (j == 0) check(32'(overlayRamAddr), 32'h00fff923);
			end
		end
		wr(4'h0, 8'h40);
		wr(4'h0, 8'h41);
		rd(4'h0, 8'hc0);
		@(negedge clock);
		check(32'(programPermit), 32'h0);
		standby(1'b0);
		rd(4'h8, 8'hff);
		standby(1'b1);
		rd(4'h8, 8'hf1);
		wr(4'h8, 8'h06);
		probe(24'h000d23);
		check(32'(overlayHit), 32'h0);
		wr(4'h8, 8'h00);
		$display("overlay test done");
	endtask

	// row: pin, mode pins, boot, user, erase writable, overlay writable
	task automatic testModes();
		logic [7:0] row [7];
		row = '{8'h9b, 8'hbb, 8'hd7, 8'hf7, 8'he1, 8'hc0, 8'h51};
		for (int r = 0; r < 7; r++)
		begin
			setMode(row[r][7], row[r][6:4]);
			@(negedge clock);
			check(32'({bootMode, userProgramMode}), 32'(row[r][3:2]));
			wr(4'h0, 8'h40);
			wr(4'h4, 8'h02);
			rd(4'h4, row[r][1] ? 8'h02 : 8'h00);
			wr(4'h8, 8'h02);
			rd(4'h8, row[r][0] ? 8'hf3 : 8'hf1);
			wr(4'h8, 8'h00);
			wr(4'h4, 8'h00);
			wr(4'h0, 8'h00);
		end
		$display("mode test done");
	endtask

	task automatic testDone();
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// clock, sequence, watchdog
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	initial
	begin
		{reset, read, write, address, writedata} = {1'b1, 1'b0, 1'b0, 4'h0, 32'h0};
		{hard_write_enable_pin, modePins, hardStandby, softStandby} = 6'b110100;
		{flashRead, flashAddr, exceptionStart, exceptionExempt, sleepExec} = 28'h0;
		errorCnt = 0;
		totalChecks = 0;
		tick(4);
		reset <= 1'b0;
		tick(6);
		testReset();
		testEraseSel();
		testBlocks();
		testError();
		testOverlay();
		testModes();
		testDone();
	end

	// a stalled bus access would otherwise hang the run
	initial
	begin
		repeat (30000) @(posedge clock);
		errorCnt++;
		testDone();
	end
endmodule
